// ==== hdl/xmem_pkg.sv ====
// package: register offsets, field layout, reset values and timing constants
package xmem_pkg;
    // ************************************************************
    // register offsets on the special-function register bus
    // ************************************************************
    localparam logic [7:0] ADDR_TIMING = 8'hA1;
    localparam logic [7:0] ADDR_PAGE = 8'hA2;
    localparam logic [7:0] ADDR_CONFIG = 8'hA3;
    localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
    localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h03;
    localparam logic [7:0] TIMING_RESET = 8'hFF;
    localparam logic [7:0] CONFIG_WRITE_MASK = 8'h3F;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CFG_PORT_BANK_BIT = 5;
    localparam int CFG_MUX_BIT = 4;
    localparam int CFG_MODE_HI = 3;
    localparam int CFG_MODE_LO = 2;
    localparam int CFG_ALE_HI = 1;
    localparam int CFG_ALE_LO = 0;
    localparam int TC_SETUP_HI = 7;
    localparam int TC_SETUP_LO = 6;
    localparam int TC_STROBE_HI = 5;
    localparam int TC_STROBE_LO = 2;
    localparam int TC_HOLD_HI = 1;
    localparam int TC_HOLD_LO = 0;
    // ************************************************************
    // memory modes and map
    // ************************************************************
    localparam logic [1:0] MODE_INTERNAL = 2'h0;
    localparam logic [1:0] MODE_SPLIT_NO_BANK = 2'h1;
    localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
    localparam logic [1:0] MODE_EXTERNAL = 2'h3;
    localparam int ONCHIP_ADDR_BITS = 12;
    // ************************************************************
    // access timing: fixed overhead beyond the programmed phases
    // ************************************************************
    localparam logic [4:0] OVERHEAD_CYCLES = 5'h4;
endpackage : xmem_pkg

// ==== hdl/xmem_cycle_counter.sv ====
// phase down-counter: loads a cycle count and flags its last cycle
`timescale 1ns/10ps
`default_nettype none
module xmem_cycle_counter #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // control
    input wire logic load_in,
    input wire logic [WIDTH-1:0] count_in,
    // status
    output logic last_out
);
    logic [WIDTH-1:0] remaining;

    if (WIDTH < 2) begin : g_width_check
        $error("counter width too small");
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            remaining <= '0;
        end else if (load_in) begin
            remaining <= count_in;
        end else if (remaining != '0) begin
            remaining <= remaining - 1'b1;
        end
    end

    assign last_out = (remaining == '0);
endmodule : xmem_cycle_counter
`default_nettype wire

// ==== hdl/xmem_addr_resolve.sv ====
// effective address forming and on-chip / off-chip routing
`timescale 1ns/10ps
`default_nettype none
module xmem_addr_resolve (
    // access request
    input wire logic wide_form_in,
    input wire logic [15:0] data_pointer_in,
    input wire logic [7:0] index_reg_in,
    // configuration
    input wire logic [7:0] page_select_bits_in,
    input wire logic [1:0] memory_mode_field_in,
    // results
    output logic [15:0] eff_addr_out,
    output logic offchip_out,
    output logic drive_high_out,
    output logic [11:0] onchip_addr_out
);
    logic above_boundary;

    always_comb begin
        eff_addr_out = wide_form_in ? data_pointer_in                      // [R01]
                                    : {page_select_bits_in, index_reg_in}; // [R02] [R10]
        above_boundary = (eff_addr_out[15:xmem_pkg::ONCHIP_ADDR_BITS] != 4'h0);
        onchip_addr_out = eff_addr_out[xmem_pkg::ONCHIP_ADDR_BITS-1:0]; // [R24] wraps on 4k [R25]
        unique case (memory_mode_field_in)
            xmem_pkg::MODE_INTERNAL: offchip_out = 1'b0;          // [R12]
            xmem_pkg::MODE_SPLIT_NO_BANK: offchip_out = above_boundary; // [R13]
            xmem_pkg::MODE_SPLIT_BANK: offchip_out = above_boundary;    // [R15]
            xmem_pkg::MODE_EXTERNAL: offchip_out = 1'b1;          // [R16]
        endcase
        // 8-bit form leaves upper address pins to the port latches except in mode 10 [R24] [R13]
        drive_high_out = wide_form_in || (memory_mode_field_in == xmem_pkg::MODE_SPLIT_BANK);
    end
endmodule : xmem_addr_resolve
`default_nettype wire

// ==== hdl/external_memory_iface.sv ====
// external data memory interface: registers, routing and off-chip bus sequencer
`timescale 1ns/10ps
`default_nettype none
// Function
// (R01) wide form addresses through data pointer
// (R02) short form uses page byte plus index
// (R03) data pointer reachable as two bytes
// (R04) bank bit picks low or high ports
// (R05) software sets crossbar skip for strobes
// (R06) pins claimed only during off-chip access
// (R07) software parks pin latches high, push-pull
// (R08) data drivers off while reading
// (R09) pin output mode never changed here
// (R10) page select resets zero, selects page
// (R11) multiplex bit: shared or separate pins
// (R12) mode 00 routes everything on-chip
// (R13) mode 01 splits; latch high byte
// (R14) software picks off-chip page first
// (R15) mode 10 splits; page gives high byte
// (R16) mode 11 routes everything off-chip
// (R17) ale field sets 1-4 cycle widths
// (R18) config resets 03, top bits zero
// (R19) multiplexed: shared pins plus ale latch
// (R20) ale high with address, then data
// (R21) external latch holds after ale falls
// (R22) access takes programmed phases plus four
// (R23) timing register resets ones, three fields
// (R24) short form leaves high address undriven; code drives it in mode 10
// (R25) internal-only mode wraps on 4k
// (R26) on-chip access uses no pins
module external_memory_iface (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // special-function register bus
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    // cpu external-move request
    input wire logic move_req_in,
    input wire logic move_write_in,
    input wire logic move_wide_in,
    input wire logic [7:0] move_index_in,
    input wire logic [7:0] move_wdata_in,
    output logic move_busy_out,
    output logic move_done_out,
    output logic [7:0] move_rdata_out,
    // on-chip data ram
    output logic ram_en_out,
    output logic ram_we_out,
    output logic [11:0] ram_addr_out,
    output logic [7:0] ram_wdata_out,
    input wire logic [7:0] ram_rdata_in,
    // port pins (active-low enables: low while driving)
    output logic port_claim_low_out,
    output logic port_claim_high_out,
    output logic muxed_mode_out,
    output logic [7:0] addr_high_out,
    output logic addr_high_oe_n_out,
    output logic [7:0] addr_low_out,
    output logic addr_low_oe_n_out,
    output logic [7:0] data_out,
    output logic data_oe_n_out,
    input wire logic [7:0] data_in,
    output logic ale_out,
    output logic rd_n_out,
    output logic wr_n_out
);
    // ************************************************************
    // state machine of the off-chip sequence
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ALE_HIGH = 3'b001,
        ST_ALE_LOW = 3'b010,
        ST_SETUP = 3'b011,
        ST_STROBE = 3'b100,
        ST_HOLD = 3'b101,
        ST_FINISH = 3'b110
    } seq_state_t;

    seq_state_t state;
    seq_state_t next_state;

    logic [7:0] page_select_bits;
    logic [7:0] external_memory_iface_configuration;
    logic [7:0] external_memory_iface_timing_control;
    logic [15:0] data_pointer;
    logic [15:0] eff_addr;
    logic offchip;
    logic drive_high;
    logic [11:0] onchip_addr;
    logic port_bank_select;
    logic bus_multiplex_select;
    logic [1:0] memory_mode_field;
    logic [1:0] ale_width_field;
    logic phase_last;
    logic phase_load;
    logic [4:0] phase_count;
    logic cur_write;
    logic cur_drive_high;
    logic [15:0] cur_addr;
    logic [7:0] cur_wdata;
    logic onchip_pending;

    assign port_bank_select = external_memory_iface_configuration[xmem_pkg::CFG_PORT_BANK_BIT];
    assign bus_multiplex_select = external_memory_iface_configuration[xmem_pkg::CFG_MUX_BIT];
    assign memory_mode_field =
        external_memory_iface_configuration[xmem_pkg::CFG_MODE_HI:xmem_pkg::CFG_MODE_LO];
    assign ale_width_field = external_memory_iface_configuration[xmem_pkg::CFG_ALE_HI:xmem_pkg::CFG_ALE_LO];

    // width of a programmed phase, in counter terms (count of cycles minus one)
    function automatic logic [4:0] phase_cycles(input logic [3:0] field, input logic plus_one);
        phase_cycles = {1'b0, field} + (plus_one ? 5'h0 : 5'h1F);
    endfunction : phase_cycles

    // ************************************************************
    // register file
    // ************************************************************
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            page_select_bits <= xmem_pkg::PAGE_RESET; // [R10]
        end else if (sfr_wr_in && sfr_addr_in == xmem_pkg::ADDR_PAGE) begin
            page_select_bits <= sfr_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            external_memory_iface_configuration <= xmem_pkg::CONFIG_RESET; // [R18]
        end else if (sfr_wr_in && sfr_addr_in == xmem_pkg::ADDR_CONFIG) begin
            external_memory_iface_configuration <= sfr_wdata_in & xmem_pkg::CONFIG_WRITE_MASK; // [R18]
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            external_memory_iface_timing_control <= xmem_pkg::TIMING_RESET; // [R23]
        end else if (sfr_wr_in && sfr_addr_in == xmem_pkg::ADDR_TIMING) begin
            external_memory_iface_timing_control <= sfr_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_pointer <= 16'h0000;
        end else if (sfr_wr_in && sfr_addr_in == xmem_pkg::ADDR_DATA_POINTER_LOW) begin
            data_pointer[7:0] <= sfr_wdata_in; // [R03]
        end else if (sfr_wr_in && sfr_addr_in == xmem_pkg::ADDR_DATA_POINTER_HIGH) begin
            data_pointer[15:8] <= sfr_wdata_in; // [R03]
        end
    end

    always_comb begin
        sfr_hit_out = 1'b1;
        unique case (sfr_addr_in)
            xmem_pkg::ADDR_PAGE: sfr_rdata_out = page_select_bits;
            xmem_pkg::ADDR_CONFIG: sfr_rdata_out = external_memory_iface_configuration;
            xmem_pkg::ADDR_TIMING: sfr_rdata_out = external_memory_iface_timing_control;
            xmem_pkg::ADDR_DATA_POINTER_LOW: sfr_rdata_out = data_pointer[7:0];   // [R03]
            xmem_pkg::ADDR_DATA_POINTER_HIGH: sfr_rdata_out = data_pointer[15:8]; // [R03]
            default: begin
                sfr_rdata_out = 8'h00;
                sfr_hit_out = 1'b0;
            end
        endcase
        if (!sfr_rd_in) begin
            sfr_rdata_out = 8'h00;
        end
    end

    // ************************************************************
    // address forming and routing
    // ************************************************************
    xmem_addr_resolve u_resolve (
        .wide_form_in(move_wide_in),
        .data_pointer_in(data_pointer),
        .index_reg_in(move_index_in),
        .page_select_bits_in(page_select_bits),
        .memory_mode_field_in(memory_mode_field),
        .eff_addr_out(eff_addr),
        .offchip_out(offchip),
        .drive_high_out(drive_high),
        .onchip_addr_out(onchip_addr)
    );

    // ************************************************************
    // on-chip path: single cycle ram access, no pins touched
    // ************************************************************
    always_comb begin
        ram_en_out = move_req_in && state == ST_IDLE && !offchip; // [R26]
        ram_we_out = ram_en_out && move_write_in;
        ram_addr_out = onchip_addr; // [R25]
        ram_wdata_out = move_wdata_in;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            onchip_pending <= 1'b0;
        end else begin
            onchip_pending <= ram_en_out && !move_write_in;
        end
    end

    // ************************************************************
    // off-chip sequencer
    // ************************************************************
    xmem_cycle_counter #(
        .WIDTH(5)
    ) u_phase (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .load_in(phase_load),
        .count_in(phase_count),
        .last_out(phase_last)
    );

    always_comb begin
        next_state = state;
        phase_load = 1'b0;
        phase_count = 5'h0;
        unique case (state)
            ST_IDLE: begin
                if (move_req_in && offchip) begin
                    phase_load = 1'b1;
                    if (!bus_multiplex_select) begin // [R11] [R19]
                        next_state = ST_ALE_HIGH;
                        phase_count = phase_cycles({2'b00, ale_width_field}, 1'b1); // [R17]
                    end else begin
                        next_state = ST_SETUP;
                        phase_count = {3'b000, external_memory_iface_timing_control[7:6]};
                    end
                end
            end
            ST_ALE_HIGH: begin
                if (phase_last) begin
                    next_state = ST_ALE_LOW; // [R20]
                    phase_load = 1'b1;
                    phase_count = phase_cycles({2'b00, ale_width_field}, 1'b1); // [R17]
                end
            end
            ST_ALE_LOW: begin
                if (phase_last) begin
                    next_state = ST_SETUP;
                    phase_load = 1'b1;
                    phase_count = {3'b000, external_memory_iface_timing_control[7:6]};
                end
            end
            ST_SETUP: begin
                // setup of zero still spends one overhead cycle here [R22]
                if (phase_last) begin
                    next_state = ST_STROBE;
                    phase_load = 1'b1;
                    phase_count = {1'b0,
                        external_memory_iface_timing_control[xmem_pkg::TC_STROBE_HI:xmem_pkg::TC_STROBE_LO]
                    }; // [R23]
                end
            end
            ST_STROBE: begin
                if (phase_last) begin
                    next_state = ST_HOLD;
                    phase_load = 1'b1;
                    phase_count = {3'b000,
                        external_memory_iface_timing_control[xmem_pkg::TC_HOLD_HI:xmem_pkg::TC_HOLD_LO]};
                end
            end
            ST_HOLD: begin
                if (phase_last) begin
                    next_state = ST_FINISH;
                    phase_load = 1'b1;
                    phase_count = xmem_pkg::OVERHEAD_CYCLES - 5'h3; // [R22]
                end
            end
            ST_FINISH: begin
                if (phase_last) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // latch the access so the bus stays stable for the whole sequence
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur_write <= 1'b0;
            cur_drive_high <= 1'b0;
            cur_addr <= 16'h0000;
            cur_wdata <= 8'h00;
        end else if (state == ST_IDLE && move_req_in && offchip) begin
            cur_write <= move_write_in;
            cur_drive_high <= drive_high; // [R24]
            cur_addr <= eff_addr;
            cur_wdata <= move_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            move_rdata_out <= 8'h00;
        end else if (onchip_pending) begin
            move_rdata_out <= ram_rdata_in;
        end else if (state == ST_STROBE && phase_last && !cur_write) begin
            move_rdata_out <= data_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            move_done_out <= 1'b0;
        end else begin
            move_done_out <= (ram_en_out) || (state == ST_FINISH && phase_last);
        end
    end

    assign move_busy_out = (state != ST_IDLE) || onchip_pending;

    // ************************************************************
    // pin drive: claimed only while off-chip sequence runs
    // ************************************************************
    always_comb begin
        logic active;
        logic shared;
        logic strobing;
        active = (state != ST_IDLE); // [R06] [R26]
        shared = !bus_multiplex_select;
        strobing = (state == ST_STROBE);
        port_claim_low_out = active && !port_bank_select;  // [R04]
        port_claim_high_out = active && port_bank_select;  // [R04]
        muxed_mode_out = shared; // [R19]
        ale_out = (state == ST_ALE_HIGH); // [R20]
        rd_n_out = !(strobing && !cur_write);
        wr_n_out = !(strobing && cur_write);
        addr_high_out = cur_addr[15:8];
        addr_high_oe_n_out = !(active && cur_drive_high); // [R24]
        addr_low_out = cur_addr[7:0];
        addr_low_oe_n_out = !(active && !shared);
        data_out = (shared && (state == ST_ALE_HIGH || state == ST_ALE_LOW))
                   ? cur_addr[7:0] : cur_wdata; // [R20]
        // read turns data drivers off; push-pull/open-drain left to port logic [R08] [R09]
        data_oe_n_out = !(active && (cur_write || (shared && state inside {ST_ALE_HIGH, ST_ALE_LOW})));
    end
endmodule : external_memory_iface
`default_nettype wire

// ==== test/xmem_asserts.sv ====
// checker: port-level assertions for the external memory interface
`timescale 1ns/10ps
`default_nettype none
module xmem_asserts (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // register bus
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_rdata_out,
    // move status and ram
    input wire logic move_busy_out,
    input wire logic ram_en_out,
    // pins
    input wire logic port_claim_low_out,
    input wire logic port_claim_high_out,
    input wire logic muxed_mode_out,
    input wire logic data_oe_n_out,
    input wire logic ale_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    wire logic claimed = port_claim_low_out | port_claim_high_out;
    wire logic no_strobe = rd_n_out & wr_n_out;
    sequence ale_fall_s;
        ale_out ##1 !ale_out;
    endsequence
    cfg_top_zero_a: assert property (
        sfr_rd_in && sfr_addr_in == xmem_pkg::ADDR_CONFIG |-> sfr_rdata_out[7:6] == 2'h0)
        else $error("config top bits not zero");
    onchip_no_pins_a: assert property (ram_en_out |-> !claimed && no_strobe)
        else $error("on-chip access touched pins");
    strobe_claims_a: assert property (!no_strobe |-> claimed)
        else $error("strobe without pin claim");
    idle_release_a: assert property (
        !move_busy_out |-> !claimed && no_strobe && !ale_out)
        else $error("pins held while idle");
    read_drv_off_a: assert property (!rd_n_out |-> data_oe_n_out)
        else $error("data driven during read");
    write_drives_a: assert property (!wr_n_out |-> !data_oe_n_out)
        else $error("data not driven during write");
    one_bank_a: assert property (!(port_claim_low_out && port_claim_high_out))
        else $error("both port banks claimed");
    ale_muxed_a: assert property (
        ale_out |-> muxed_mode_out && claimed && no_strobe)
        else $error("ale outside multiplexed address phase");
    ale_then_data_a: assert property (ale_fall_s |-> no_strobe)
        else $error("strobe at ale fall");
    hold_after_a: assert property ($rose(rd_n_out) || $rose(wr_n_out) |-> claimed)
        else $error("no hold phase after strobe");
endmodule : xmem_asserts
bind external_memory_iface xmem_asserts u_xmem_asserts (.*);
`default_nettype wire

// ==== test/xmem_sram_model.sv ====
// partner: off-chip byte memory behind a low-address latch
`timescale 1ns/10ps
`default_nettype none
module xmem_sram_model (
    // bus from the interface
    input wire logic muxed_in,
    input wire logic ale_in,
    input wire logic [7:0] addr_high_in,
    input wire logic addr_high_oe_n_in,
    input wire logic [7:0] addr_low_in,
    input wire logic [7:0] ad_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    // read data back
    output logic [7:0] data_out
);
    logic [7:0] mem [0:65535];
    logic [7:0] low_latch;
    logic [7:0] wbuf;
    logic [7:0] last = 8'h00;
    logic [15:0] addr;
    always_latch begin
        if (ale_in) low_latch <= ad_in;
    end
    always_latch begin
        if (!wr_n_in) wbuf <= ad_in;
    end
    // undriven high pins sit at the parked port latch level
    assign addr = {addr_high_oe_n_in ? 8'hFF : addr_high_in,
        muxed_in ? low_latch : addr_low_in};
    always @(posedge wr_n_in) mem[addr] <= wbuf;
    always @(posedge rd_n_in) last <= mem[addr];
    // released lines show the inverse of the last value
    assign data_out = rd_n_in ? ~last : mem[addr];
endmodule : xmem_sram_model
`default_nettype wire

// ==== test/external_memory_iface_tb_top.sv ====
// testbench: register and move scenarios
`timescale 1ns/10ps
`default_nettype none
module external_memory_iface_tb_top;
    logic sys_clk_in, rst_in, sfr_wr_in, sfr_rd_in, sfr_hit_out;
    logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, move_index_in, move_wdata_in;
    logic move_req_in, move_write_in, move_wide_in, move_busy_out, move_done_out;
    logic [7:0] move_rdata_out, ram_wdata_out, ram_rdata_in, addr_high_out, addr_low_out;
    logic [7:0] data_out, data_in;
    logic [11:0] ram_addr_out;
    logic [12:0] ram_a;
    logic ram_en_out, ram_we_out, port_claim_low_out, port_claim_high_out, muxed_mode_out;
    logic addr_high_oe_n_out, addr_low_oe_n_out, data_oe_n_out, ale_out, rd_n_out, wr_n_out;
    logic [15:0] ale_n, stb_n, clm_n;
    logic ram_hit, saw_hi, hi_drv;
    int n_errors = 0;
    int checks_done = 0;
    external_memory_iface DUT (.*);
    xmem_sram_model u_mem (.muxed_in(muxed_mode_out), .ale_in(ale_out),
        .addr_high_in(addr_high_out), .addr_high_oe_n_in(addr_high_oe_n_out),
        .addr_low_in(addr_low_out), .ad_in(data_out), .rd_n_in(rd_n_out),
        .wr_n_in(wr_n_out), .data_out(data_in));
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    // per-access cycle counters, cleared at the taking edge
    always @(posedge sys_clk_in) begin
        ram_rdata_in <= ram_addr_out[7:0] ^ 8'h5A;
        if (ram_en_out) ram_a <= {ram_we_out, ram_addr_out};
        if (move_req_in && !move_busy_out) begin
            {ale_n, stb_n, clm_n, saw_hi, hi_drv} <= '0;
            ram_hit <= ram_en_out;
        end else begin
            ale_n <= ale_n + 16'(ale_out);
            stb_n <= stb_n + 16'(!(rd_n_out && wr_n_out));
            clm_n <= clm_n + 16'(port_claim_low_out | port_claim_high_out);
            saw_hi <= saw_hi | port_claim_high_out;
            hi_drv <= hi_drv | !addr_high_oe_n_out;
            ram_hit <= ram_hit | ram_en_out;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        sfr_wr_in <= 1'b1;
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        @(posedge sys_clk_in);
        sfr_wr_in <= 1'b0;
    endtask : sfr_write
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        sfr_rd_in <= 1'b1;
        sfr_addr_in <= a;
        @(negedge sys_clk_in);
        check({7'h00, sfr_hit_out, sfr_rdata_out}, {7'h00, a != 8'h90, exp});
        @(posedge sys_clk_in);
        sfr_rd_in <= 1'b0;
    endtask : sfr_read
    task automatic move(input logic w, input logic wide, input logic [7:0] idx,
        input logic [7:0] wd);
        int i;
        @(posedge sys_clk_in);
        move_req_in <= 1'b1;
        move_write_in <= w;
        move_wide_in <= wide;
        move_index_in <= idx;
        move_wdata_in <= wd;
        @(posedge sys_clk_in);
        move_req_in <= 1'b0;
        for (i = 0; i < 200 && move_done_out !== 1'b1; i++) @(negedge sys_clk_in);
        if (i == 200) check(16'h0000, 16'h0001);
        @(negedge sys_clk_in);
    endtask : move
    task automatic results();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (6000) @(posedge sys_clk_in);
        n_errors++;
        results();
    end
    initial begin
        rst_in = 1'b1;
        {sfr_wr_in, sfr_rd_in, move_req_in, move_write_in, move_wide_in} = '0;
        {sfr_addr_in, sfr_wdata_in, move_index_in, move_wdata_in} = '0;
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        sfr_read(xmem_pkg::ADDR_PAGE, 8'h00);
        sfr_read(xmem_pkg::ADDR_CONFIG, 8'h03);
        sfr_read(xmem_pkg::ADDR_TIMING, 8'hFF);
        sfr_read(8'h90, 8'h00);
        sfr_write(xmem_pkg::ADDR_CONFIG, 8'hFF);
        sfr_read(xmem_pkg::ADDR_CONFIG, 8'h3F);
        sfr_write(xmem_pkg::ADDR_DATA_POINTER_HIGH, 8'h10);
        sfr_write(xmem_pkg::ADDR_DATA_POINTER_LOW, 8'h34);
        sfr_read(xmem_pkg::ADDR_DATA_POINTER_HIGH, 8'h10);
        sfr_read(xmem_pkg::ADDR_DATA_POINTER_LOW, 8'h34);
        // internal only: wide 0x1034 wraps to 0x034
        sfr_write(xmem_pkg::ADDR_CONFIG, 8'h10);
        move(1'b1, 1'b1, 8'h00, 8'h55);
        check(ram_hit, 16'h0001);
        check(ram_a, 16'h1034);
        check(clm_n, 16'h0000);
        sfr_write(xmem_pkg::ADDR_PAGE, 8'h20);
        move(1'b0, 1'b0, 8'h07, 8'h00);
        check(ram_a, 16'h0007);
        check(move_rdata_out, 16'h005D);
        // split, no bank, separate pins, longest timing
        sfr_write(xmem_pkg::ADDR_CONFIG, 8'h14);
        sfr_write(xmem_pkg::ADDR_PAGE, 8'h12);
        check(muxed_mode_out, 16'h0000);
        move(1'b1, 1'b0, 8'h56, 8'h77);
        check(clm_n, 16'd26);
        check(stb_n, 16'd16);
        check(hi_drv, 16'h0000);
        check(saw_hi, 16'h0000);
        sfr_write(xmem_pkg::ADDR_DATA_POINTER_HIGH, 8'h0A);
        sfr_write(xmem_pkg::ADDR_DATA_POINTER_LOW, 8'hBC);
        move(1'b0, 1'b1, 8'h00, 8'h00);
        check(ram_a, 16'h0ABC);
        check(move_rdata_out, 16'h00E6);
        sfr_write(xmem_pkg::ADDR_DATA_POINTER_HIGH, 8'h23);
        sfr_write(xmem_pkg::ADDR_DATA_POINTER_LOW, 8'h45);
        move(1'b1, 1'b1, 8'h00, 8'h5A);
        check(hi_drv, 16'h0001);
        move(1'b0, 1'b1, 8'h00, 8'h00);
        check(move_rdata_out, 16'h005A);
        // split with bank, multiplexed, high port bank, ale code 2
        sfr_write(xmem_pkg::ADDR_CONFIG, 8'h2A);
        sfr_write(xmem_pkg::ADDR_TIMING, 8'h0D);
        check(muxed_mode_out, 16'h0001);
        move(1'b1, 1'b0, 8'h56, 8'hA5);
        check(ale_n, 16'd3);
        check(stb_n, 16'd4);
        check(clm_n, 16'd15);
        check(saw_hi, 16'h0001);
        move(1'b0, 1'b0, 8'h56, 8'h00);
        check(move_rdata_out, 16'h00A5);
        check(hi_drv, 16'h0001);
        sfr_write(xmem_pkg::ADDR_PAGE, 8'h0F);
        move(1'b0, 1'b0, 8'h01, 8'h00);
        check(ram_a, 16'h0F01);
        // external only: page ignored, high pins left parked
        sfr_write(xmem_pkg::ADDR_CONFIG, 8'h1C);
        sfr_write(xmem_pkg::ADDR_PAGE, 8'h00);
        move(1'b0, 1'b0, 8'h56, 8'h00);
        check(move_rdata_out, 16'h0077);
        check(hi_drv, 16'h0000);
        check(clm_n, 16'd9);
        results();
    end
endmodule : external_memory_iface_tb_top
`default_nettype wire
